/* rtl/dbm_monitor.sv */
// Block interrupt counter and program counter monitor with register port
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module dbm_monitor
  import dbm_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               sys_rst,
  input  wire logic               frame_start,
  input  wire dbm_pkg::dbm_pc_t   pc_value,
  input  wire dbm_pkg::dbm_word_t reg_addr,
  input  wire dbm_pkg::dbm_word_t reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output var  dbm_pkg::dbm_word_t reg_rdata,
  output var  logic               block_irq_pulse,
  output var  logic               irq
);

  logic                block_irq_enable;
  dbm_word_t           block_frame_limit;
  dbm_word_t           block_count;
  logic [DBM_ST_W-1:0] irq_status;
  logic [DBM_ST_W-1:0] irq_mask;
  dbm_pc_t             frame_peak;
  dbm_pc_t             run_peak;
  dbm_pc_t             max_peak;

  logic                next_block_irq_enable;
  dbm_word_t           next_block_frame_limit;
  dbm_word_t           next_block_count;
  logic [DBM_ST_W-1:0] next_irq_status;
  logic [DBM_ST_W-1:0] next_irq_mask;
  dbm_pc_t             next_frame_peak;
  dbm_word_t           next_reg_rdata;
  logic                next_block_irq_pulse;
  logic                next_irq;

  dbm_word_t           count_inc;
  logic                limit_hit;
  logic                block_evt;
  logic                boundary;
  logic                pc_peak_clear;
  logic [DBM_ST_W-1:0] w1c;

  // Block frame counter
  always_comb
  begin
    count_inc = block_count + 16'h0001;
    limit_hit = frame_start && (count_inc == block_frame_limit);
    block_evt = limit_hit && block_irq_enable;                     // [R04]
    if (limit_hit)
      next_block_count = DBM_RST_WORD;                             // [R03]
    else if (frame_start)
      next_block_count = count_inc;                                // [R02]
    else
      next_block_count = block_count;
    next_block_irq_pulse = block_evt;                              // [R03]
    // With block processing on, the last-frame peak spans a whole block
    boundary = block_irq_enable ? limit_hit : frame_start;         // [R11]
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      block_count     <= DBM_RST_WORD;
      block_irq_pulse <= 1'b0;
    end
    else
    begin
      block_count     <= next_block_count;
      block_irq_pulse <= next_block_irq_pulse;
    end
  end

  // Peak tracking
  assign pc_peak_clear = (reg_wr || reg_rd) && (reg_addr == DBM_ADDR_CLEAR);  // [R10]

  dbm_peak_track u_run_peak (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .clear   (pc_peak_clear),
    .restart (boundary),
    .sample  (pc_value),
    .peak    (run_peak)
  );

  dbm_peak_track u_max_peak (                                      // [R08]
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .clear   (pc_peak_clear),
    .restart (1'b0),
    .sample  (pc_value),
    .peak    (max_peak)
  );

  always_comb
  begin
    if (pc_peak_clear)
      next_frame_peak = DBM_RST_PC;                                // [R10]
    else if (boundary)
      next_frame_peak = dbm_max(run_peak, pc_value);               // [R06]
    else
      next_frame_peak = frame_peak;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      frame_peak <= DBM_RST_PC;
    else
      frame_peak <= next_frame_peak;
  end

  // Control, status and mask registers
  always_comb
  begin
    next_block_irq_enable  = block_irq_enable;
    next_block_frame_limit = block_frame_limit;
    next_irq_mask          = irq_mask;
    w1c                    = DBM_RST_ST;
    if (reg_wr)
    begin
      case (reg_addr)
        DBM_ADDR_IRQ_EN: next_block_irq_enable  = reg_wdata[DBM_EN_BIT];   // [R04]
        DBM_ADDR_LIMIT:  next_block_frame_limit = reg_wdata;               // [R01]
        DBM_ADDR_MASK:   next_irq_mask          = reg_wdata[DBM_ST_W-1:0];
        DBM_ADDR_STATUS: w1c                    = reg_wdata[DBM_ST_W-1:0];
        default:         w1c                    = DBM_RST_ST;              // [R12]
      endcase
    end
    // A new event wins over a clear in the same cycle
    next_irq_status = irq_status & ~w1c;
    next_irq_status[DBM_ST_BLOCK_BIT] = next_irq_status[DBM_ST_BLOCK_BIT] | block_evt;
    next_irq_status[DBM_ST_FRAME_BIT] = next_irq_status[DBM_ST_FRAME_BIT] | frame_start;
    next_irq = |(next_irq_status & next_irq_mask);
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      block_irq_enable  <= 1'b0;
      block_frame_limit <= DBM_RST_WORD;
      irq_mask          <= DBM_RST_ST;
      irq_status        <= DBM_RST_ST;
      irq               <= 1'b0;
    end
    else
    begin
      block_irq_enable  <= next_block_irq_enable;
      block_frame_limit <= next_block_frame_limit;
      irq_mask          <= next_irq_mask;
      irq_status        <= next_irq_status;
      irq               <= next_irq;
    end
  end

  // Read port, data valid the cycle after the strobe
  always_comb
  begin
    next_reg_rdata = DBM_RD_NONE;
    if (reg_rd)
    begin
      case (reg_addr)
        DBM_ADDR_IRQ_EN: next_reg_rdata = {15'h0000, block_irq_enable};
        DBM_ADDR_LIMIT:  next_reg_rdata = block_frame_limit;
        DBM_ADDR_PC_HI:  next_reg_rdata = dbm_upper(pc_value);             // [R05]
        DBM_ADDR_PC_LO:  next_reg_rdata = pc_value[15:0];                  // [R05]
        DBM_ADDR_FPK_HI: next_reg_rdata = dbm_upper(frame_peak);           // [R06]
        DBM_ADDR_FPK_LO: next_reg_rdata = frame_peak[15:0];                // [R07]
        DBM_ADDR_MAX_HI: next_reg_rdata = dbm_upper(max_peak);             // [R09]
        DBM_ADDR_MAX_LO: next_reg_rdata = max_peak[15:0];                  // [R09]
        DBM_ADDR_STATUS: next_reg_rdata = {14'h0000, irq_status};
        DBM_ADDR_MASK:   next_reg_rdata = {14'h0000, irq_mask};
        default:         next_reg_rdata = DBM_RD_NONE;                     // [R12]
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      reg_rdata <= DBM_RD_NONE;
    else
      reg_rdata <= next_reg_rdata;
  end

  // Checks
  default clocking dbm_cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  limit_write_a: assert property (                                  // [R01]
    reg_wr && (reg_addr == DBM_ADDR_LIMIT) |=> block_frame_limit == $past(reg_wdata))
    else $error("block length not stored");

  count_step_a: assert property (                                   // [R02]
    frame_start && !limit_hit |=> block_count == $past(block_count) + 16'h0001)
    else $error("frame counter did not advance");

  block_wrap_a: assert property (                                   // [R03]
    limit_hit |=> (block_count == DBM_RST_WORD) && (block_irq_pulse == $past(block_irq_enable)))
    else $error("block end not handled");

  irq_gate_a: assert property (                                     // [R04]
    block_irq_pulse |-> $past(block_irq_enable) && $past(limit_hit) && irq_status[DBM_ST_BLOCK_BIT])
    else $error("block interrupt without enable");

  pc_read_a: assert property (                                      // [R05]
    reg_rd && (reg_addr == DBM_ADDR_PC_HI) |=> reg_rdata == {8'h00, $past(pc_value[23:16])})
    else $error("program counter upper byte wrong");

  frame_peak_a: assert property (                                   // [R06]
    boundary && !pc_peak_clear |=> frame_peak == dbm_max($past(run_peak), $past(pc_value)))
    else $error("frame peak not captured");

  peak_low_read_a: assert property (                                // [R07]
    reg_rd && (reg_addr == DBM_ADDR_FPK_LO) && !boundary |=> reg_rdata == frame_peak[15:0])
    else $error("frame peak low word wrong");

  max_keep_a: assert property (                                     // [R08]
    !pc_peak_clear |=> (max_peak >= $past(max_peak)) && (max_peak >= $past(pc_value)))
    else $error("highest peak lost");

  max_split_a: assert property (                                    // [R09]
    reg_rd && (reg_addr == DBM_ADDR_MAX_HI) |=> reg_rdata[15:8] == 8'h00)
    else $error("highest peak reserved byte not zero");

  peak_clear_a: assert property (                                   // [R10]
    pc_peak_clear |=> (frame_peak == DBM_RST_PC) && (max_peak == DBM_RST_PC) && (run_peak == DBM_RST_PC))
    else $error("peaks not cleared");

  ro_write_a: assert property (                                     // [R12]
    reg_wr && (reg_addr == DBM_ADDR_MAX_LO) && !pc_peak_clear |=> max_peak >= $past(max_peak))
    else $error("read-only peak changed by write");

  irq_level_a: assert property (
    frame_start ##1 irq_mask[DBM_ST_FRAME_BIT] |-> irq)
    else $error("masked-in event did not raise interrupt");

  limit_read_a: assert property (                                   // [R01]
    reg_rd && (reg_addr == DBM_ADDR_LIMIT) |=> reg_rdata == $past(block_frame_limit))
    else $error("block length read back wrong");

  count_hold_a: assert property (                                   // [R02]
    !frame_start |=> block_count == $past(block_count))
    else $error("frame counter moved without a frame");

  hit_only_pulse_a: assert property (                               // [R03]
    !limit_hit |=> !block_irq_pulse)
    else $error("block interrupt without block end");

  en_write_a: assert property (                                     // [R04]
    reg_wr && (reg_addr == DBM_ADDR_IRQ_EN) |=> block_irq_enable == $past(reg_wdata[DBM_EN_BIT]))
    else $error("block interrupt enable not stored");

  en_read_a: assert property (                                      // [R04]
    reg_rd && (reg_addr == DBM_ADDR_IRQ_EN) |=> reg_rdata == {15'h0000, $past(block_irq_enable)})
    else $error("block interrupt enable read back wrong");

  off_no_pulse_a: assert property (                                 // [R04]
    !block_irq_enable |=> !block_irq_pulse)
    else $error("block interrupt while disabled");

  pc_low_read_a: assert property (                                  // [R05]
    reg_rd && (reg_addr == DBM_ADDR_PC_LO) |=> reg_rdata == $past(pc_value[15:0]))
    else $error("program counter low word wrong");

  fpk_hi_read_a: assert property (                                  // [R06]
    reg_rd && (reg_addr == DBM_ADDR_FPK_HI) |=> reg_rdata == {8'h00, $past(frame_peak[23:16])})
    else $error("frame peak upper byte wrong");

  frame_hold_a: assert property (                                   // [R06]
    !boundary && !pc_peak_clear |=> frame_peak == $past(frame_peak))
    else $error("frame peak changed between boundaries");

  max_exact_a: assert property (                                    // [R08]
    !pc_peak_clear |=> max_peak == dbm_max($past(max_peak), $past(pc_value)))
    else $error("highest peak not tracked");

  max_hi_read_a: assert property (                                  // [R09]
    reg_rd && (reg_addr == DBM_ADDR_MAX_HI) |=> reg_rdata == {8'h00, $past(max_peak[23:16])})
    else $error("highest peak upper byte wrong");

  max_lo_read_a: assert property (                                  // [R09]
    reg_rd && (reg_addr == DBM_ADDR_MAX_LO) |=> reg_rdata == $past(max_peak[15:0]))
    else $error("highest peak low word wrong");

  run_restart_a: assert property (                                  // [R11]
    boundary && !pc_peak_clear |=> run_peak == $past(pc_value))
    else $error("running peak not restarted");

  run_follow_a: assert property (                                   // [R11]
    !boundary && !pc_peak_clear |=> run_peak == dbm_max($past(run_peak), $past(pc_value)))
    else $error("running peak not tracked");

  rdata_idle_a: assert property (                                   // [R12]
    !reg_rd |=> reg_rdata == DBM_RD_NONE)
    else $error("read data not idle");

  status_set_a: assert property (
    frame_start |=> irq_status[DBM_ST_FRAME_BIT])
    else $error("frame status bit not set");

  status_clear_a: assert property (
    reg_wr && (reg_addr == DBM_ADDR_STATUS) && reg_wdata[DBM_ST_FRAME_BIT] && !frame_start
    |=> !irq_status[DBM_ST_FRAME_BIT])
    else $error("frame status bit not cleared");

  irq_match_a: assert property (
    irq == |(irq_status & irq_mask))
    else $error("interrupt level does not follow status and mask");

endmodule
`default_nettype wire

/* rtl/dbm_peak_track.sv */
// Peak tracker for a 24-bit program counter with clear and restart
`timescale 1ns/100ps
`default_nettype none
module dbm_peak_track
  import dbm_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic             clear,
  input  wire logic             restart,
  input  wire dbm_pkg::dbm_pc_t sample,
  output var  dbm_pkg::dbm_pc_t peak
);

  dbm_pc_t next_peak;

  always_comb
  begin
    if (clear)
      next_peak = DBM_RST_PC;                 // [R10]
    else if (restart)
      next_peak = sample;                     // [R11]
    else
      next_peak = dbm_max(peak, sample);      // [R11]
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      peak <= DBM_RST_PC;
    else
      peak <= next_peak;
  end

endmodule
`default_nettype wire

/* rtl/dbm_pkg.sv */
// Constants, types and helpers shared by the DSP block interrupt and program counter monitor
// What this block does
// R01 - Software writes a 16-bit block length, in audio frames, per processing block.
// R02 - The block frame counter advances by one on every frame start pulse.
// R03 - Counter equal to block length raises a block interrupt and returns to zero.
// R04 - Block interrupts fire only while the enable bit is one; enable resets to zero.
// R05 - Live 24-bit program counter readable; upper byte in low byte of upper register.
// R06 - Peak program counter of the last frame or block is kept and readable.
// R07 - Low 16 bits of last-frame peak read as a read-only word, reset zero.
// R08 - Highest program counter peak since start is kept across frames until cleared.
// R09 - Highest peak split: bits 23:16 in one register, 15:0 in the next, reset zero.
// R10 - Any access to the clear register resets both peak values.
// R11 - Peaks follow any larger program counter; last-frame tracker restarts at boundaries.
// R12 - Reserved bits read zero; writes to read-only fields have no effect.
`default_nettype none
package dbm_pkg;

  typedef logic [15:0] dbm_word_t;
  typedef logic [23:0] dbm_pc_t;

  // Register map
  localparam dbm_word_t DBM_ADDR_IRQ_EN  = 16'hF450;
  localparam dbm_word_t DBM_ADDR_LIMIT   = 16'hF451;
  localparam dbm_word_t DBM_ADDR_PC_HI   = 16'hF460;
  localparam dbm_word_t DBM_ADDR_PC_LO   = 16'hF461;
  localparam dbm_word_t DBM_ADDR_CLEAR   = 16'hF462;
  localparam dbm_word_t DBM_ADDR_FPK_HI  = 16'hF463;
  localparam dbm_word_t DBM_ADDR_FPK_LO  = 16'hF464;
  localparam dbm_word_t DBM_ADDR_MAX_HI  = 16'hF465;
  localparam dbm_word_t DBM_ADDR_MAX_LO  = 16'hF466;
  localparam dbm_word_t DBM_ADDR_STATUS  = 16'hF470;
  localparam dbm_word_t DBM_ADDR_MASK    = 16'hF471;

  // Field positions
  localparam int DBM_EN_BIT       = 0;
  localparam int DBM_ST_BLOCK_BIT = 0;
  localparam int DBM_ST_FRAME_BIT = 1;
  localparam int DBM_ST_W         = 2;

  // Reset values
  localparam dbm_word_t             DBM_RST_WORD  = 16'h0000;
  localparam dbm_pc_t               DBM_RST_PC    = 24'h000000;
  localparam logic [DBM_ST_W-1:0]   DBM_RST_ST    = 2'h0;
  localparam dbm_word_t             DBM_RD_NONE   = 16'h0000;

  function automatic dbm_pc_t dbm_max(input dbm_pc_t a, input dbm_pc_t b);
    dbm_max = (a > b) ? a : b;
  endfunction

  // Upper byte of a 24-bit value in the low byte of a word, reserved byte zero
  function automatic dbm_word_t dbm_upper(input dbm_pc_t v);
    dbm_upper = {8'h00, v[23:16]};
  endfunction

endpackage
`default_nettype wire

/* sim/dbm_core_model.sv */
// Model of the DSP core: frame start pulses and a live program counter
`timescale 1ns/100ps
`default_nettype none
module dbm_core_model
  import dbm_pkg::*;
(
  input  wire logic             clk_sys,
  output var  logic             frame_start,
  output var  dbm_pkg::dbm_pc_t pc_value
);
  import dbm_pkg::*;

  initial
  begin
    frame_start = 1'b0;
    pc_value    = 24'h000000;
  end

  // Program counter changes right after an edge and then holds
  task automatic set_pc(input dbm_pc_t v);
    @(posedge clk_sys);
    pc_value <= v;
  endtask

  // One-cycle frame start pulse
  task automatic frame();
    @(posedge clk_sys);
    frame_start <= 1'b1;
    @(posedge clk_sys);
    frame_start <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* sim/dbm_monitor_tb.sv */
// Self-checking testbench for the block interrupt and program counter monitor
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module dbm_monitor_tb;
  import dbm_pkg::*;
  logic      clk_sys;
  logic      sys_rst;
  logic      frame_start;
  dbm_pc_t   pc_value;
  dbm_word_t reg_addr;
  dbm_word_t reg_wdata;
  logic      reg_wr;
  logic      reg_rd;
  dbm_word_t reg_rdata;
  logic      block_irq_pulse;
  logic      irq;
  int        miscompares = 0;
  int        checked = 0;
  int        pulses = 0;
  int        exp_pulses = 0;
  dbm_word_t lim = 16'h0000;
  dbm_word_t cnt = 16'h0000;
  logic      en = 1'b0;
  dbm_word_t all_regs [11] = '{DBM_ADDR_IRQ_EN, DBM_ADDR_LIMIT, DBM_ADDR_PC_HI, DBM_ADDR_PC_LO,
    DBM_ADDR_CLEAR, DBM_ADDR_FPK_HI, DBM_ADDR_FPK_LO, DBM_ADDR_MAX_HI, DBM_ADDR_MAX_LO,
    DBM_ADDR_STATUS, DBM_ADDR_MASK};

  dbm_core_model u_core (.clk_sys(clk_sys), .frame_start(frame_start), .pc_value(pc_value));
  dbm_monitor u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .frame_start(frame_start), .pc_value(pc_value),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .block_irq_pulse(block_irq_pulse), .irq(irq));

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
    if (block_irq_pulse === 1'b1) pulses++;

  task automatic complete_run();
    if (miscompares == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(input dbm_word_t a, input dbm_word_t d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input dbm_word_t a, input dbm_word_t e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    `CHK("reg_rdata", e, reg_rdata)
  endtask

  // Frame pulse plus the expected counter wrap and pulse
  task automatic frm();
    u_core.frame();
    cnt = cnt + 16'h0001;
    if (cnt == lim)
    begin
      cnt = 16'h0000;
      if (en) exp_pulses++;
    end
  endtask

  task automatic wait_chk_irq(input logic e);
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK("irq", e, irq)
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    complete_run();
  end

  initial
  begin
    sys_rst = 1'b1;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    foreach (all_regs[i]) rd(all_regs[i], 16'h0000);
    rd(16'hF452, 16'h0000);
    u_core.set_pc(24'h12ABCD);
    rd(DBM_ADDR_PC_HI, 16'h0012);
    rd(DBM_ADDR_PC_LO, 16'hABCD);
    wr(DBM_ADDR_PC_HI, 16'hFFFF);
    rd(DBM_ADDR_PC_HI, 16'h0012);
    wr(DBM_ADDR_IRQ_EN, 16'hFFFF);
    rd(DBM_ADDR_IRQ_EN, 16'h0001);
    wr(DBM_ADDR_IRQ_EN, 16'h0000);
    u_core.set_pc(24'h345678);
    u_core.set_pc(24'h010000);
    rd(DBM_ADDR_MAX_HI, 16'h0034);
    rd(DBM_ADDR_MAX_LO, 16'h5678);
    frm();
    rd(DBM_ADDR_FPK_HI, 16'h0034);
    rd(DBM_ADDR_FPK_LO, 16'h5678);
    frm();
    rd(DBM_ADDR_FPK_HI, 16'h0001);
    rd(DBM_ADDR_FPK_LO, 16'h0000);
    u_core.set_pc(24'h000100);
    wr(DBM_ADDR_CLEAR, 16'h0000);
    rd(DBM_ADDR_MAX_HI, 16'h0000);
    rd(DBM_ADDR_MAX_LO, 16'h0100);
    rd(DBM_ADDR_FPK_HI, 16'h0000);
    u_core.set_pc(24'h000300);
    u_core.set_pc(24'h000050);
    rd(DBM_ADDR_CLEAR, 16'h0000);
    repeat (2) @(posedge clk_sys);
    rd(DBM_ADDR_MAX_LO, 16'h0050);
    lim = 16'h0003;
    wr(DBM_ADDR_LIMIT, lim);
    rd(DBM_ADDR_LIMIT, 16'h0003);
    wr(DBM_ADDR_STATUS, 16'h0003);
    wr(DBM_ADDR_MASK, 16'h0001);
    en = 1'b1;
    wr(DBM_ADDR_IRQ_EN, 16'h0001);
    repeat (4) frm();
    wait_chk_irq(1'b1);
    `CHK("pulses", exp_pulses, pulses)
    rd(DBM_ADDR_STATUS, 16'h0003);
    wr(DBM_ADDR_STATUS, 16'h0001);
    rd(DBM_ADDR_STATUS, 16'h0002);
    wait_chk_irq(1'b0);
    en = 1'b0;
    wr(DBM_ADDR_IRQ_EN, 16'h0000);
    repeat (3) frm();
    rd(DBM_ADDR_STATUS, 16'h0002);
    wait_chk_irq(1'b0);
    `CHK("pulses", exp_pulses, pulses)
    lim = 16'h0001;
    wr(DBM_ADDR_LIMIT, lim);
    en = 1'b1;
    wr(DBM_ADDR_IRQ_EN, 16'h0001);
    repeat (2) frm();
    repeat (2) @(posedge clk_sys);
    `CHK("pulses", exp_pulses, pulses)
    wait_chk_irq(1'b1);
    // Reset in mid-run: registers, counter and interrupt return to idle
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    lim = 16'h0000;
    cnt = 16'h0000;
    en = 1'b0;
    #1;
    `CHK("irq", 1'b0, irq)
    rd(DBM_ADDR_IRQ_EN, 16'h0000);
    rd(DBM_ADDR_LIMIT, 16'h0000);
    rd(DBM_ADDR_STATUS, 16'h0000);
    rd(DBM_ADDR_FPK_LO, 16'h0000);
    // Block mode: the last-frame peak spans the whole block
    lim = 16'h0002;
    wr(DBM_ADDR_LIMIT, lim);
    en = 1'b1;
    wr(DBM_ADDR_IRQ_EN, 16'h0001);
    u_core.set_pc(24'h000200);
    u_core.set_pc(24'h000010);
    repeat (2) frm();
    rd(DBM_ADDR_FPK_LO, 16'h0200);
    `CHK("pulses", exp_pulses, pulses)
    complete_run();
  end
endmodule
`default_nettype wire
